// [verilog/cmr_regs.sv]
// Collision report and general mode registers with their side logic
`timescale 1ns/100ps
module cmr_regs (
  // Clock, reset, enable
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  // Host register port
  input  wire cmr_pkg::cmr_host_req_s host_i,
  output logic                 [7:0]  rdata_o,
  output logic                        rvalid_o,
  // Receiver side
  input  wire cmr_pkg::cmr_rx_s       rx_i,
  input  wire logic            [2:0]  rx_align_i,
  output logic                        rx_out_valid_o,
  output logic                        rx_out_bit_o,
  output logic                 [2:0]  rx_out_pos_o,
  // CRC coprocessor side
  input  wire logic                   crc_rf_comm_i,
  input  wire logic                   crc_rx_dir_i,
  input  wire logic            [1:0]  tx_framing_i,
  input  wire logic            [1:0]  rx_framing_i,
  input  wire logic            [15:0] crc_raw_i,
  output logic                        crc_msb_first_o,
  output logic                 [15:0] crc_seed_o,
  output logic                 [15:0] crc_result_o,
  // Transmitter side
  input  wire logic                   tx_start_req_i,
  input  wire logic                   rf_field_on_i,
  output logic                        tx_start_o,
  // Envelope input
  input  wire logic                   envelope_input_pin_i,
  output logic                        env_internal_b_o,
  output logic                        envelope_input_active_event_o
);
  import cmr_pkg::*;

  // ****************************************************************
  // Host registers
  // ****************************************************************
  cmr_mode_s  mode, next_mode;
  logic       keep, next_keep;
  logic       pos_invalid;
  logic [4:0] pos;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_event;
  logic       wr_mode;
  logic       wr_coll;

  // Address decode for this part of the bank
  always_comb begin
    wr_mode = host_i.wr && (host_i.addr == OFS_MODE);
    wr_coll = host_i.wr && (host_i.addr == OFS_COLL);
  end

  // Next values for writable fields and read data
  always_comb begin
    next_mode   = mode;
    next_keep   = keep;
    next_event  = 1'b0;
    next_rdata  = 8'h00;
    next_rvalid = host_i.rd;
    if (wr_coll) begin
      next_keep = host_i.wdata[COLL_KEEP_BIT];
    end
    if (wr_mode) begin
      next_mode.msb_order  = host_i.wdata[MODE_MSB_BIT];
      next_mode.wait_field = host_i.wdata[MODE_WAIT_BIT];
      next_mode.env_pol    = host_i.wdata[MODE_POL_BIT];
      next_mode.seed_sel   = host_i.wdata[1:0];
      // Any change of polarity looks like an envelope edge
      next_event = host_i.wdata[MODE_POL_BIT] != mode.env_pol;
    end
    if (host_i.rd) begin
      case (host_i.addr)
        OFS_COLL:  next_rdata = {keep, 1'b0, pos_invalid, pos};
        OFS_RSV_A: next_rdata = RSV_RST;
        OFS_RSV_B: next_rdata = RSV_RST;
        // Reserved bits 4 and 2 show the reset pattern and never change
        OFS_MODE:  next_rdata = MODE_RSV_READ | {mode.msb_order, 1'b0, mode.wait_field, 1'b0,
                                                  mode.env_pol, 1'b0, mode.seed_sel};
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  // Register the host-visible state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode.msb_order                <= MODE_RST[MODE_MSB_BIT];
      mode.wait_field               <= MODE_RST[MODE_WAIT_BIT];
      mode.env_pol                  <= MODE_RST[MODE_POL_BIT];
      mode.seed_sel                 <= MODE_RST[1:0];
      keep                          <= COLL_KEEP_RST;
      rdata_o                       <= 8'h00;
      rvalid_o                      <= 1'b0;
      envelope_input_active_event_o <= 1'b0;
    end else if (ce_i) begin
      mode                          <= next_mode;
      keep                          <= next_keep;
      rdata_o                       <= next_rdata;
      rvalid_o                      <= next_rvalid;
      envelope_input_active_event_o <= next_event;
    end
  end

  // ****************************************************************
  // Collision tracking
  // ****************************************************************
  cmr_frame_e frame, next_frame;
  logic [5:0] cnt, next_cnt;
  logic       seen, next_seen;
  logic       next_invalid;
  logic [4:0] next_pos;
  logic       next_out_valid;
  logic       next_out_bit;
  logic [2:0] next_out_pos;
  logic [5:0] idx;

  // Count data bits only; the receiver strobes no parity or framing bits
  always_comb begin
    next_frame     = frame;
    next_cnt       = cnt;
    next_seen      = seen;
    next_invalid   = pos_invalid;
    next_pos       = pos;
    next_out_valid = 1'b0;
    next_out_bit   = 1'b0;
    next_out_pos   = rx_out_pos_o;
    idx            = cnt + 6'h01;
    case (frame)
      CMR_IDLE: begin
        if (rx_i.frame_start) begin
          next_frame   = CMR_IN_FRAME;
          next_cnt     = 6'h00;
          next_seen    = 1'b0;
          next_invalid = 1'b1;
          next_pos     = 5'h00;
        end
      end
      CMR_IN_FRAME: begin
        if (rx_i.data_valid) begin
          // Saturate so long frames cannot wrap back into range
          if (cnt != BIT_CNT_MAX) begin
            next_cnt = idx;
          end
          if (rx_i.collision && !seen) begin
            next_seen = 1'b1;
            if (idx <= POS_SPAN) begin
              next_invalid = 1'b0;
              next_pos     = idx[4:0];
            end
          end
          next_out_valid = 1'b1;
          // Collided bit and all later ones are cleared unless kept
          next_out_bit   = (!keep && (seen || rx_i.collision)) ? 1'b0 : rx_i.data_bit;
          next_out_pos   = rx_align_i + cnt[2:0];
        end
        if (rx_i.frame_end) begin
          next_frame = CMR_IDLE;
        end
      end
      default: next_frame = CMR_IDLE;
    endcase
  end

  // Register collision state; reset values are not part of the contract
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame          <= CMR_IDLE;
      cnt            <= 6'h00;
      seen           <= 1'b0;
      pos_invalid    <= 1'b1;
      pos            <= 5'h00;
      rx_out_valid_o <= 1'b0;
      rx_out_bit_o   <= 1'b0;
      rx_out_pos_o   <= 3'h0;
    end else if (ce_i) begin
      frame          <= next_frame;
      cnt            <= next_cnt;
      seen           <= next_seen;
      pos_invalid    <= next_invalid;
      pos            <= next_pos;
      rx_out_valid_o <= next_out_valid;
      rx_out_bit_o   <= next_out_bit;
      rx_out_pos_o   <= next_out_pos;
    end
  end

  // ****************************************************************
  // CRC, transmitter and envelope qualifiers
  // ****************************************************************
  logic        next_msb_first;
  logic [15:0] next_seed;
  logic [15:0] seed_sel_val;
  logic [15:0] next_result;
  logic        next_tx_start;
  logic        next_env_b;

  cmr_crc_seed u_seed (
    .seed_sel_i   (mode.seed_sel),
    .rf_comm_i    (crc_rf_comm_i),
    .rx_dir_i     (crc_rx_dir_i),
    .tx_framing_i (tx_framing_i),
    .rx_framing_i (rx_framing_i),
    .seed_o       (seed_sel_val)
  );

  // Qualify mode bits against the live status of the datapath
  always_comb begin
    next_msb_first = mode.msb_order && !crc_rf_comm_i;
    next_seed      = seed_sel_val;
    next_result    = crc_raw_i;
    if (next_msb_first) begin
      next_result = {cmr_rev8(crc_raw_i[15:8]), cmr_rev8(crc_raw_i[7:0])};
    end
    // With wait_field set, a request without field is dropped, not held; the sequencer retries
    next_tx_start = tx_start_req_i && (!mode.wait_field || rf_field_on_i);
    // Internal envelope is active low whichever pin polarity is chosen
    next_env_b    = mode.env_pol ? !envelope_input_pin_i : envelope_input_pin_i;
  end

  // Register the qualified outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_msb_first_o  <= 1'b0;
      crc_seed_o       <= SEED_0;
      crc_result_o     <= 16'h0000;
      tx_start_o       <= 1'b0;
      env_internal_b_o <= 1'b1;
    end else if (ce_i) begin
      crc_msb_first_o  <= next_msb_first;
      crc_seed_o       <= next_seed;
      crc_result_o     <= next_result;
      tx_start_o       <= next_tx_start;
      env_internal_b_o <= next_env_b;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_discard_after: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && frame == CMR_IN_FRAME && rx_i.data_valid && !keep && (seen || rx_i.collision)
    |=> rx_out_valid_o && !rx_out_bit_o)
    else $error("bit kept after collision");

  chk_invalid_nocoll: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && rx_i.frame_start && frame == CMR_IDLE |=> pos_invalid)
    else $error("invalid flag not set at frame start");

  chk_pos_first: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && frame == CMR_IN_FRAME && rx_i.data_valid && rx_i.collision && !seen && cnt < 6'h1f
    |=> !pos_invalid && pos == $past(cnt[4:0]) + 5'h01)
    else $error("collision position wrong");

  chk_pos_wrap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && frame == CMR_IN_FRAME && rx_i.data_valid && rx_i.collision && !seen && cnt == 6'h1f
    |=> !pos_invalid && pos == 5'h00)
    else $error("thirty-second bit not reported as zero");

  chk_msb_rf_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && crc_rf_comm_i |=> !crc_msb_first_o && crc_result_o == $past(crc_raw_i))
    else $error("msb order applied during RF");

  chk_crc_reverse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && mode.msb_order && !crc_rf_comm_i
    |=> crc_result_o[15] == $past(crc_raw_i[8]) && crc_result_o[0] == $past(crc_raw_i[7]))
    else $error("crc bytes not reversed");

  chk_tx_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && mode.wait_field && !rf_field_on_i |=> !tx_start_o)
    else $error("transmitter started without field");

  chk_env_event: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && wr_mode && host_i.wdata[MODE_POL_BIT] != mode.env_pol
    |=> envelope_input_active_event_o ##1 (!ce_i || !envelope_input_active_event_o || wr_mode))
    else $error("polarity change without event");

  chk_rsv_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && host_i.rd && (host_i.addr == OFS_RSV_A || host_i.addr == OFS_RSV_B)
    |=> rvalid_o && rdata_o == 8'h00)
    else $error("reserved slot not zero");

  chk_seed_std: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && !crc_rf_comm_i && mode.seed_sel == 2'h2 |=> crc_seed_o == 16'ha671)
    else $error("standalone seed wrong");

endmodule : cmr_regs

// [shared/cmr_pkg.sv]
// Constants, carriers and helpers for the collision and mode register block
package cmr_pkg;

  // ****************************************************************
  // Register offsets and field positions
  // ****************************************************************
  localparam int unsigned ADDR_W        = 6;
  localparam logic [5:0]  OFS_COLL      = 6'h0e;
  localparam logic [5:0]  OFS_RSV_A     = 6'h0f;
  localparam logic [5:0]  OFS_RSV_B     = 6'h10;
  localparam logic [5:0]  OFS_MODE      = 6'h11;
  localparam int unsigned COLL_KEEP_BIT = 7;
  localparam int unsigned COLL_INV_BIT  = 5;
  localparam int unsigned MODE_MSB_BIT  = 7;
  localparam int unsigned MODE_WAIT_BIT = 5;
  localparam int unsigned MODE_POL_BIT  = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0]  MODE_RST      = 8'h3f;
  localparam logic [7:0]  MODE_RSV_READ = 8'h14;
  localparam logic [7:0]  RSV_RST       = 8'h00;
  localparam logic        COLL_KEEP_RST = 1'b1;

  // ****************************************************************
  // Counts and CRC seeds
  // ****************************************************************
  localparam logic [5:0]  POS_SPAN      = 6'h20;
  localparam logic [5:0]  BIT_CNT_MAX   = 6'h21;
  localparam logic [15:0] SEED_0        = 16'h0000;
  localparam logic [15:0] SEED_1        = 16'h6363;
  localparam logic [15:0] SEED_2        = 16'ha671;
  localparam logic [15:0] SEED_3        = 16'hffff;
  localparam logic [1:0]  FRAMING_B     = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       msb_order;
    logic       wait_field;
    logic       env_pol;
    logic [1:0] seed_sel;
  } cmr_mode_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cmr_host_req_s;

  typedef struct packed {
    logic frame_start;
    logic data_valid;
    logic data_bit;
    logic collision;
    logic frame_end;
  } cmr_rx_s;

  typedef enum logic {CMR_IDLE, CMR_IN_FRAME} cmr_frame_e;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] cmr_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : cmr_rev8

  function automatic logic [15:0] cmr_seed_lut(input logic [1:0] sel);
    logic [15:0] s;
    s = SEED_0;
    case (sel)
      2'h1:    s = SEED_1;
      2'h2:    s = SEED_2;
      2'h3:    s = SEED_3;
      default: s = SEED_0;
    endcase
    return s;
  endfunction : cmr_seed_lut

endpackage : cmr_pkg

// [verilog/cmr_crc_seed.sv]
// CRC seed selection for standalone and RF operation
`timescale 1ns/100ps
module cmr_crc_seed (
  // Selection inputs
  input  wire logic [1:0]  seed_sel_i,
  input  wire logic        rf_comm_i,
  input  wire logic        rx_dir_i,
  input  wire logic [1:0]  tx_framing_i,
  input  wire logic [1:0]  rx_framing_i,
  // Seed
  output logic      [15:0] seed_o
);
  import cmr_pkg::*;

  logic [1:0] framing;

  // During RF traffic the framing of the active direction decides the seed
  always_comb begin
    framing = rx_dir_i ? rx_framing_i : tx_framing_i;
    if (rf_comm_i) begin
      seed_o = (framing == FRAMING_B) ? SEED_3 : SEED_1;
    end else begin
      seed_o = cmr_seed_lut(seed_sel_i);
    end
  end

endmodule : cmr_crc_seed

// [dv/cmr_host_model.sv]
// Host controller model that drives the register port of the collision and mode block
`timescale 1ns/100ps
module cmr_host_model (
  // Clock
  input  wire logic                   clock_i,
  // Register port
  output cmr_pkg::cmr_host_req_s      host_o,
  input  wire logic            [7:0]  rdata_i,
  input  wire logic                   rvalid_i
);
  import cmr_pkg::*;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Port idle from time zero
  initial begin
    host_o = '0;
  end

  // Write strobe stands for one cycle; data is scrambled afterwards so nothing stale lingers
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock_i);
    host_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    host_o.wr    = 1'b0;
    host_o.wdata = ~d;
  endtask : write_reg

  // Read answer stands for one cycle after the strobe, so it is taken there
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(negedge clock_i);
    host_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    host_o.rd = 1'b0;
    d         = rdata_i;
    v         = rvalid_i;
  endtask : read_reg

  // ****************************************************************
  // Host policy
  // ****************************************************************
  // Keep flag is lowered only around an anticollision pass and raised again after it
  task automatic set_keep(input logic keep);
    write_reg(OFS_COLL, {keep, 7'h00});
  endtask : set_keep

  // Position field is only trusted while the invalid flag is low
  function automatic logic pos_usable(input logic [7:0] r);
    return !r[COLL_INV_BIT];
  endfunction : pos_usable
endmodule : cmr_host_model

// [dv/tb.sv]
// Self-checking testbench for the collision and mode register block
`timescale 1ns/100ps
module tb;
  import cmr_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic          clock_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          ce      = 1'b1;
  cmr_host_req_s host;
  logic [7:0]    rdata;
  logic          rvalid;
  cmr_rx_s       rx      = '0;
  logic [2:0]    align   = 3'h0;
  logic          rx_ov, rx_ob, msb_o, tx_st, env_b, env_ev;
  logic [2:0]    rx_op;
  logic          rf_comm = 1'b0, rx_dir = 1'b0, tx_req = 1'b0, field = 1'b0, env_pin = 1'b0;
  logic [1:0]    tx_fr   = 2'h0, rx_fr = 2'h0;
  logic [15:0]   raw     = 16'h1234;
  logic [15:0]   seed_o, res_o;
  int            bad_count = 0, checked = 0, cyc = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  // Block under test and its host
  cmr_regs dut_u (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce), .host_i(host), .rdata_o(rdata), .rvalid_o(rvalid),
    .rx_i(rx), .rx_align_i(align), .rx_out_valid_o(rx_ov), .rx_out_bit_o(rx_ob), .rx_out_pos_o(rx_op),
    .crc_rf_comm_i(rf_comm), .crc_rx_dir_i(rx_dir), .tx_framing_i(tx_fr), .rx_framing_i(rx_fr),
    .crc_raw_i(raw), .crc_msb_first_o(msb_o), .crc_seed_o(seed_o), .crc_result_o(res_o),
    .tx_start_req_i(tx_req), .rf_field_on_i(field), .tx_start_o(tx_st),
    .envelope_input_pin_i(env_pin), .env_internal_b_o(env_b), .envelope_input_active_event_o(env_ev));
  cmr_host_model host_u (.clock_i(clock_i), .host_o(host), .rdata_i(rdata), .rvalid_i(rvalid));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host_u.read_reg(a, d, v);
    chk({15'h0, v}, 16'h1, "read answer");
    chk({8'h0, d}, {8'h0, exp}, "read data");
  endtask : rd_chk

  task automatic step(input int n);
    repeat (n) @(negedge clock_i);
  endtask : step

  task automatic pulse_rx(input cmr_rx_s v);
    @(negedge clock_i);
    rx = v;
    @(negedge clock_i);
    rx = '0;
  endtask : pulse_rx

  task automatic tx_try(input logic exp);
    @(negedge clock_i);
    tx_req = 1'b1;
    @(negedge clock_i);
    tx_req = 1'b0;
    chk({15'h0, tx_st}, {15'h0, exp}, "tx start");
  endtask : tx_try

  // Frame of n data bits with the collision on bit c (0 = none)
  task automatic frame(input int n, input int c);
    pulse_rx(5'b10000);
    for (int i = 1; i <= n; i++) begin
      pulse_rx({1'b0, 1'b1, 1'b1, (i == c), 1'b0});
    end
    pulse_rx(5'b00001);
  endtask : frame

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd_chk(OFS_MODE, 8'h3f);
    rd_chk(OFS_RSV_A, 8'h00);
    rd_chk(OFS_RSV_B, 8'h00);
    host_u.write_reg(OFS_RSV_A, 8'hff);
    host_u.write_reg(OFS_RSV_B, 8'hff);
    rd_chk(OFS_RSV_A, 8'h00);
    rd_chk(OFS_RSV_B, 8'h00);
    rd_chk(6'h3f, 8'h00);
    host_u.write_reg(OFS_MODE, 8'hff);
    rd_chk(OFS_MODE, 8'hbf);
    // Reset in mid-run must bring the mode register back
    rst_b_i = 1'b0;
    step(2);
    rst_b_i = 1'b1;
    rd_chk(OFS_MODE, 8'h3f);
    // A write while the enable is low must leave no trace
    ce = 1'b0;
    host_u.write_reg(OFS_MODE, 8'h37);
    ce = 1'b1;
    chk({15'h0, env_ev}, 16'h0, "no event while frozen");
    rd_chk(OFS_MODE, 8'h3f);
    host_u.write_reg(OFS_MODE, 8'h3f);
  endtask : t_regs

  // Polarity flip must raise the event exactly once
  task automatic t_env;
    env_pin = 1'b1;
    step(1);
    chk({15'h0, env_b}, 16'h0, "env high pol");
    host_u.write_reg(OFS_MODE, 8'h37);
    chk({15'h0, env_ev}, 16'h1, "event set");
    step(1);
    chk({14'h0, env_ev, env_b}, 16'h1, "env low pol");
    env_pin = 1'b0;
    step(1);
    chk({15'h0, env_b}, 16'h0, "env low pol act");
    host_u.write_reg(OFS_MODE, 8'h3f);
    chk({15'h0, env_ev}, 16'h1, "event back");
  endtask : t_env

  task automatic t_tx;
    field = 1'b0;
    tx_try(1'b0);
    field = 1'b1;
    tx_try(1'b1);
    field = 1'b0;
    host_u.write_reg(OFS_MODE, 8'h1f);
    tx_try(1'b1);
    host_u.write_reg(OFS_MODE, 8'h3f);
  endtask : t_tx

  task automatic t_crc;
    logic [15:0] seeds [4];
    seeds = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    for (int i = 0; i < 4; i++) begin
      host_u.write_reg(OFS_MODE, {6'h0f, i[1:0]});
      step(2);
      chk(seed_o, seeds[i], "standalone seed");
    end
    rf_comm = 1'b1;
    tx_fr   = 2'h3;
    step(2);
    chk(seed_o, 16'hffff, "rf seed type b");
    tx_fr = 2'h0;
    step(2);
    chk(seed_o, 16'h6363, "rf seed type a");
    rx_dir = 1'b1;
    rx_fr  = 2'h3;
    step(2);
    chk(seed_o, 16'hffff, "rf seed rx");
    host_u.write_reg(OFS_MODE, 8'hbf);
    step(2);
    chk({15'h0, msb_o}, 16'h0, "msb ignored in rf");
    chk(res_o, 16'h1234, "result in rf");
    rf_comm = 1'b0;
    step(2);
    chk({15'h0, msb_o}, 16'h1, "msb standalone");
    chk(res_o, 16'h482c, "reversed result");
    host_u.write_reg(OFS_MODE, 8'h3f);
  endtask : t_crc

  // Anticollision frame with discard, then position boundaries
  task automatic t_coll;
    int         n_t [4];
    int         c_t [4];
    logic [7:0] e_t [4];
    logic [7:0] d;
    logic       v;
    n_t = '{8, 32, 33, 4};
    c_t = '{8, 32, 33, 0};
    e_t = '{8'h88, 8'h80, 8'ha0, 8'ha0};
    host_u.set_keep(1'b0);
    align = 3'h3;
    pulse_rx(5'b10000);
    pulse_rx(5'b01100);
    chk({11'h0, rx_ov, rx_ob, rx_op}, 16'h1b, "first bit kept");
    pulse_rx(5'b01110);
    chk({11'h0, rx_ov, rx_ob, rx_op}, 16'h14, "collided bit");
    pulse_rx(5'b01100);
    chk({11'h0, rx_ov, rx_ob, rx_op}, 16'h15, "bit after collision");
    pulse_rx(5'b00001);
    rd_chk(OFS_COLL, 8'h02);
    // Host policy must find the reported position trustworthy here
    host_u.read_reg(OFS_COLL, d, v);
    chk({15'h0, host_u.pos_usable(d)}, 16'h1, "position usable");
    host_u.set_keep(1'b1);
    for (int i = 0; i < 4; i++) begin
      frame(n_t[i], c_t[i]);
      rd_chk(OFS_COLL, e_t[i]);
    end
  endtask : t_coll

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic test_done;
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    step(10);
    rst_b_i = 1'b1;
    t_regs();
    t_env();
    t_tx();
    t_crc();
    t_coll();
    test_done();
  end
endmodule : tb
